// ===== verif/rfs_drive_model.sv
// behavioural drive: takes data frames, answers them, sends register frames
`timescale 1ns/1ps
`default_nettype none
module rfs_drive_model (
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic         tx_valid_i,
  input  wire logic [31:0]  tx_data_i,
  input  wire logic         tx_last_i,
  input  wire logic         fail_i,
  input  wire logic         send_i,
  input  wire logic [159:0] fis_i,
  input  wire logic         rx_ready_i,
  output logic              tx_ready_o,
  output logic              tx_ok_o,
  output logic              tx_err_o,
  output logic              rx_valid_o,
  output logic [159:0]      rx_fis_o
);
  logic [31:0] words[$];
  int          seed = 32'h50022156;
  initial {tx_ready_o, tx_ok_o, tx_err_o, rx_valid_o, rx_fis_o} = '0;
  always @(posedge clock_i) begin
    tx_ready_o <= $random(seed);
    tx_ok_o <= 1'b0;
    tx_err_o <= 1'b0;
    if (sys_rst_i) rx_valid_o <= 1'b0;
    if (!sys_rst_i && tx_valid_i && tx_ready_o) begin
      words.push_back(tx_data_i);
      tx_ok_o <= tx_last_i && !fail_i;
      tx_err_o <= tx_last_i && fail_i;
    end
    if (send_i) begin
      rx_valid_o <= 1'b1;
      rx_fis_o <= fis_i;
    end else if (rx_valid_o && rx_ready_i) begin
      rx_valid_o <= 1'b0;
      rx_fis_o <= ~rx_fis_o;
    end
  end
endmodule
`default_nettype wire

// ===== verif/rfs_port_fsm_sva.sv
// concurrent checks on the port state machine ports
`timescale 1ns/1ps
`default_nettype none
module rfs_port_fsm_sva (
  input wire logic         clock_i,
  input wire logic         sys_rst_i,
  input wire logic [3:0]   current_pm_port_i,
  input wire logic [31:0]  received_fis_base_i,
  input wire logic         fis_switching_enable_i,
  input wire logic         reg_fis_intr_clr_i,
  input wire logic         global_intr_enable_i,
  input wire logic         ccc_count_clr_i,
  input wire logic [31:0]  bytes_transferred_i,
  input wire logic         rx_fis_valid_i,
  input wire logic [159:0] rx_fis_i,
  input wire logic         rx_fis_ready_o,
  input wire logic         mem_wr_valid_o,
  input wire logic [31:0]  mem_wr_addr_o,
  input wire logic         prd_wr_valid_o,
  input wire logic [31:0]  prd_wr_count_o,
  input wire logic [7:0]   task_file_status_byte_o,
  input wire logic [7:0]   task_file_error_byte_o,
  input wire logic [5:0]   issued_slot_tracker_o,
  input wire logic [31:0]  device_signature_reg_o,
  input wire logic [7:0]   coalesced_completion_count_o,
  input wire logic         reg_fis_intr_status_o,
  input wire logic         global_port_intr_pending_o,
  input wire logic         port_intr_o,
  input wire logic         fatal_taskfile_o
);
  import rfs_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  wire take = rx_fis_valid_i && rx_fis_ready_o && rx_fis_i[7:0] == FIS_TYPE_REG_D2H;
  property p_sts;
    take |=> task_file_status_byte_o == $past(rx_fis_i[23:16]);
  endproperty
  a_sts: assert property (p_sts) else $error("status byte wrong");
  property p_err;
    take |=> task_file_error_byte_o == $past(rx_fis_i[31:24]);
  endproperty
  a_err: assert property (p_err) else $error("error byte wrong");
  property p_addr;
    $rose(mem_wr_valid_o) && $past(take) |-> mem_wr_addr_o ==
      received_fis_base_i + REGISTER_FIS_OFFSET + {20'h0, current_pm_port_i, 8'h0};
  endproperty
  a_addr: assert property (p_addr) else $error("fis copy address wrong");
  property p_ftf;
    fatal_taskfile_o |-> task_file_status_byte_o[STS_ERR_BIT];
  endproperty
  a_ftf: assert property (p_ftf) else $error("fatal without error bit");
  property p_prd;
    prd_wr_valid_o |-> prd_wr_count_o == bytes_transferred_i && issued_slot_tracker_o == NO_SLOT
      && (task_file_status_byte_o & 8'h89) == 8'h00;
  endproperty
  a_prd: assert property (p_prd) else $error("completion wrong");
  property p_ccc;
    coalesced_completion_count_o != $past(coalesced_completion_count_o) && !$past(ccc_count_clr_i)
      |-> coalesced_completion_count_o == $past(coalesced_completion_count_o) + 8'h01;
  endproperty
  a_ccc: assert property (p_ccc) else $error("count step wrong");
  property p_hold;
    port_intr_o && !reg_fis_intr_clr_i |=> port_intr_o;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped");
  property p_gen;
    $rose(port_intr_o) |-> global_port_intr_pending_o && reg_fis_intr_status_o
      && global_intr_enable_i;
  endproperty
  a_gen: assert property (p_gen) else $error("interrupt without cause");
  property p_fbs;
    fis_switching_enable_i && $past(fis_switching_enable_i) |-> $stable(device_signature_reg_o);
  endproperty
  a_fbs: assert property (p_fbs) else $error("signature moved");
endmodule
`default_nettype wire

// ===== verif/rfs_port_fsm_test.sv
// self-checking bench for the port state machine
`timescale 1ns/1ps
`default_nettype none
module rfs_port_fsm_test;
  import rfs_pkg::*;
  logic clock_i, sys_rst_i, fis_switching_enable_i, ccc_enable_i, reg_fis_intr_enable_i;
  logic global_intr_enable_i, slot_issue_i, pending_packet_set_i, signature_update_req_i;
  logic reg_fis_intr_clr_i, global_pending_clr_i, ccc_count_clr_i, atapi_start_i, mem_wr_ready_i;
  logic tx_ready_i, tx_ok_i, tx_err_i, rx_fis_valid_i, rx_fis_ready_o, tx_valid_o, tx_last_o;
  logic mem_wr_valid_o, prd_wr_valid_o, pending_signature_update_o, reg_fis_intr_status_o;
  logic global_port_intr_pending_o, port_intr_o, fatal_o, fatal_taskfile_o, pio_update_o, aggr_o;
  logic fail, send, is, epend;
  logic [3:0]   current_pm_port_i, cmd_header_pm_port_i;
  logic [4:0]   slot_issue_num_i, prd_wr_slot_o, pslot;
  logic [5:0]   issued_slot_tracker_o;
  logic [7:0]   task_file_status_byte_o, task_file_error_byte_o, coalesced_completion_count_o;
  logic [7:0]   ecnt, ests;
  logic [15:0]  current_transfer_count_i, pending_packet_transfer_o;
  logic [31:0]  received_fis_base_i, active_tag_bits_i, command_issue_set_i, bytes_transferred_i;
  logic [31:0]  tx_data_o, mem_wr_addr_o, mem_wr_data_o, prd_wr_count_o, command_issue_bits_o;
  logic [31:0]  device_signature_reg_o, pcnt, eci, esig, maddr[$], mdata[$];
  logic [127:0] packet_command_area_i;
  logic [159:0] rx_fis_i, fis;
  logic [2:0]   eintr;
  int seed = 32'h50022156;
  int err_count = 0, checks = 0, n_end = 0, n_ftf = 0, n_prd = 0, n_pio = 0, n_fat = 0;
  int cl[6] = '{0, 3, 4, 13, 16, 40};
  rfs_port_fsm dut (.*);
  rfs_drive_model drv (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .fail_i(fail), .send_i(send), .fis_i(fis),
    .rx_ready_i(rx_fis_ready_o), .tx_ready_o(tx_ready_i), .tx_ok_o(tx_ok_i),
    .tx_err_o(tx_err_i), .rx_valid_o(rx_fis_valid_i), .rx_fis_o(rx_fis_i));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    mem_wr_ready_i <= $random(seed);
    if (mem_wr_valid_o && mem_wr_ready_i) begin
      maddr.push_back(mem_wr_addr_o);
      mdata.push_back(mem_wr_data_o);
    end
    if (prd_wr_valid_o) {pslot, pcnt} <= {prd_wr_slot_o, prd_wr_count_o};
    n_prd <= n_prd + prd_wr_valid_o;
    n_ftf <= n_ftf + fatal_taskfile_o;
    n_pio <= n_pio + pio_update_o;
    n_fat <= n_fat + fatal_o;
    n_end <= n_end + (aggr_o | fatal_taskfile_o | pio_update_o | fatal_o);
  end
  task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wait_end(input int e0);
    for (int i = 0; i < 300 && n_end == e0; i++) @(posedge clock_i);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    {eci, ecnt, eintr, epend, esig, ests} = {40'h0, 4'h0, SIGNATURE_RESET, TFD_STATUS_RESET};
    #1;
    chk({task_file_status_byte_o, device_signature_reg_o, issued_slot_tracker_o},
        {TFD_STATUS_RESET, SIGNATURE_RESET, NO_SLOT});
  endtask
  task automatic send_pkt(input logic [15:0] cnt, input logic bad);
    int w0, e0, p0, f0, n;
    n = ((cnt > PACKET_CMD_MAX_BYTES ? PACKET_CMD_MAX_BYTES : cnt) + 3) / 4;
    w0 = drv.words.size();
    {e0, p0, f0} = {n_end, n_pio, n_fat};
    @(posedge clock_i);
    current_transfer_count_i <= cnt;
    packet_command_area_i <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    {cmd_header_pm_port_i, current_pm_port_i} <= $random(seed);
    {pending_packet_set_i, fail} <= {1'b1, bad};
    @(posedge clock_i);
    {pending_packet_set_i, atapi_start_i} <= 2'b01;
    @(posedge clock_i);
    atapi_start_i <= 1'b0;
    wait_end(e0);
    chk(drv.words.size() - w0, n + 1);
    chk(drv.words[w0][11:0], {cmd_header_pm_port_i, FIS_TYPE_DATA});
    for (int k = 0; k < n; k++)
      chk(drv.words[w0 + 1 + k], packet_command_area_i[32 * k +: 32]);
    chk({n_pio - p0, n_fat - f0}, {32'(!bad), 32'(bad)});
    chk(pending_packet_transfer_o[current_pm_port_i], 1'b0);
  endtask
  task automatic reg_fis(input logic [7:0] sts, input logic [7:0] typ);
    logic [4:0] s;
    logic cmp;
    int e0, f0, p0;
    {e0, f0, p0} = {n_end, n_ftf, n_prd};
    s = $random(seed);
    cmp = (sts & 8'h89) == 8'h00;
    fis = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    fis[31:16] = {fis[31:24], sts};
    fis[7:0] = typ;
    @(posedge clock_i);
    {current_pm_port_i, ccc_enable_i, reg_fis_intr_enable_i, global_intr_enable_i} <= $random(seed);
    {fis_switching_enable_i, signature_update_req_i, slot_issue_i} <= {2'($random(seed)), 1'b1};
    {received_fis_base_i, active_tag_bits_i, bytes_transferred_i} <= {3{$random(seed)}};
    {slot_issue_num_i, command_issue_set_i} <= {s, 32'h1 << s};
    @(posedge clock_i);
    {slot_issue_i, command_issue_set_i, send} <= {33'h0, 1'b1};
    signature_update_req_i <= 1'b0;
    epend = epend | signature_update_req_i;
    eci = eci | (32'h1 << s);
    @(posedge clock_i);
    send <= 1'b0;
    if (typ != FIS_TYPE_REG_D2H) begin
      repeat (12) @(posedge clock_i);
      #1;
      chk({maddr.size(), task_file_status_byte_o}, {32'h0, ests});
      return;
    end
    ests = sts;
    wait_end(e0);
    chk({task_file_status_byte_o, task_file_error_byte_o}, {sts, fis[31:24]});
    chk({n_ftf - f0, n_prd - p0}, {32'(sts[STS_ERR_BIT]), 32'(cmp)});
    chk(maddr.size(), 5);
    for (int k = 0; k < 5; k++) chk({maddr.pop_front(), mdata.pop_front()},
      {received_fis_base_i + REGISTER_FIS_OFFSET + 32'(current_pm_port_i) * 256 + 4 * k,
       fis[32 * k +: 32]});
    if (cmp) eci = eci & ~(32'h1 << s);
    if (cmp) chk({pslot, pcnt}, {s, bytes_transferred_i});
    chk({command_issue_bits_o, issued_slot_tracker_o},
        {eci, cmp ? NO_SLOT : {1'b0, s}});
    ecnt = ecnt + (cmp && ccc_enable_i && !active_tag_bits_i[s]);
    chk(coalesced_completion_count_o, ecnt);
    is = cmp && fis[FIS_IBIT];
    eintr = eintr | {is, is && reg_fis_intr_enable_i,
                     is && reg_fis_intr_enable_i && global_intr_enable_i};
    chk({reg_fis_intr_status_o, global_port_intr_pending_o, port_intr_o},
        eintr);
    if (!sts[STS_ERR_BIT] && epend && !fis_switching_enable_i)
      {esig, epend} = {fis[55:32], fis[103:96], 1'b0};
    chk({device_signature_reg_o, pending_signature_update_o}, {esig, epend});
    if ($random(seed) & 1) begin
      {reg_fis_intr_clr_i, global_pending_clr_i, ccc_count_clr_i} <= 3'h7;
      @(posedge clock_i);
      {reg_fis_intr_clr_i, global_pending_clr_i, ccc_count_clr_i} <= 3'h0;
      {eintr, ecnt} = 11'h0;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock_i);
    err_count++;
    end_of_test();
  end
  initial begin
    {sys_rst_i, fis_switching_enable_i, ccc_enable_i} = 3'h0;
    {reg_fis_intr_enable_i, global_intr_enable_i} = 2'h1;
    {slot_issue_i, pending_packet_set_i, signature_update_req_i, reg_fis_intr_clr_i} = 4'h0;
    {global_pending_clr_i, ccc_count_clr_i, atapi_start_i, mem_wr_ready_i, fail, send} = 6'h0;
    {current_pm_port_i, cmd_header_pm_port_i, slot_issue_num_i, current_transfer_count_i} = '0;
    {received_fis_base_i, active_tag_bits_i, command_issue_set_i, bytes_transferred_i} = '0;
    {packet_command_area_i, fis} = '0;
    do_reset();
    foreach (cl[i]) send_pkt(cl[i], i[0]);
    for (int i = 0; i < 6; i++) send_pkt($random(seed), $random(seed));
    reg_fis(8'h50, FIS_TYPE_REG_D2H);
    reg_fis(8'h51, FIS_TYPE_REG_D2H);
    reg_fis(8'h88, FIS_TYPE_REG_D2H);
    reg_fis(8'h58, 8'h27);
    for (int i = 0; i < 30; i++) reg_fis($random(seed) & 8'hf9, FIS_TYPE_REG_D2H);
    do_reset();
    for (int i = 0; i < 10; i++) reg_fis($random(seed), FIS_TYPE_REG_D2H);
    end_of_test();
  end
endmodule
bind rfs_port_fsm rfs_port_fsm_sva chk (.*);
`default_nettype wire

// ===== verilog/rfs_pkg.sv
// shared constants and types for the register fis receive state machine
package rfs_pkg;
  // fis type codes
  localparam logic [7:0]  FIS_TYPE_REG_D2H   = 8'h34;
  localparam logic [7:0]  FIS_TYPE_DATA      = 8'h46;
  // received-fis area layout
  localparam logic [31:0] REGISTER_FIS_OFFSET = 32'h0000_0040;
  localparam int          PM_PORT_AREA_SHIFT  = 8;
  localparam logic [31:0] DWORD_BYTES         = 32'h0000_0004;
  localparam logic [2:0]  REG_FIS_DWORDS      = 3'h5;
  // packet command limits
  localparam logic [15:0] PACKET_CMD_MAX_BYTES = 16'h0010;
  // slot tracking
  localparam logic [5:0]  NO_SLOT            = 6'h20;
  localparam int          NUM_SLOTS          = 32;
  localparam int          NUM_PM_PORTS       = 16;
  // status byte fields
  localparam int          STS_ERR_BIT        = 0;
  localparam int          STS_DRQ_BIT        = 3;
  localparam int          STS_BSY_BIT        = 7;
  // dword 0 fields of a fis
  localparam int          FIS_PMP_LSB        = 8;
  localparam int          FIS_IBIT           = 14;
  localparam int          FIS_STATUS_LSB     = 16;
  localparam int          FIS_ERROR_LSB      = 24;
  // reset values
  localparam logic [7:0]  TFD_STATUS_RESET   = 8'h7f;
  localparam logic [7:0]  TFD_ERROR_RESET    = 8'h00;
  localparam logic [31:0] SIGNATURE_RESET    = 32'hffff_ffff;
  localparam logic [7:0]  CCC_COUNT_RESET    = 8'h00;

  typedef enum logic [3:0] {
    RFS_IDLE       = 4'h0,
    RFS_ATAPI_SEND = 4'h1,
    RFS_ATAPI_WAIT = 4'h2,
    RFS_REG_ENTRY  = 4'h3,
    RFS_REG_CHECK  = 4'h4,
    RFS_CLEAR_CI   = 4'h5,
    RFS_CCC        = 4'h6,
    RFS_SET_INTR   = 4'h7,
    RFS_SET_IS     = 4'h8,
    RFS_GEN_INTR   = 4'h9,
    RFS_UPDATE_SIG = 4'ha,
    RFS_SET_SIG    = 4'hb,
    RFS_AGGR       = 4'hc
  } rfs_state_t;
endpackage

// ===== verilog/rfs_port_fsm.sv
// packet command send and d2h register fis receive state machine for one port
// Overview of operation
// - data fis carries min(count, 16) packet bytes
// - data fis pmp field from command header
// - clear pending packet flag after sending
// - send error to fatal, ok to pio update
// - only a valid register fis starts handling
// - copy fis to base+256*pmp+offset
// - load task file error byte from fis
// - load task file status byte from fis
// - err, bsy and drq clear go to completion
// - write transferred byte count to header
// - clear issue bit, tracker set to 32
// - coalescing when enabled and tag clear
// - coalescing count adds one, then branch
// - set register fis interrupt status bit
// - set global pending, enable gates interrupt
// - assert port interrupt then signature check
// - pending signature update selects signature write
// - no signature update under fis switching
// - write signature, clear pending, then aggregate
`timescale 1ns/1ps
`default_nettype none
module rfs_port_fsm (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  current_pm_port_i,
  input  wire logic [31:0] received_fis_base_i,
  input  wire logic        fis_switching_enable_i,
  input  wire logic        ccc_enable_i,
  input  wire logic [31:0] active_tag_bits_i,
  input  wire logic        reg_fis_intr_enable_i,
  input  wire logic        global_intr_enable_i,
  input  wire logic        slot_issue_i,
  input  wire logic [4:0]  slot_issue_num_i,
  input  wire logic [31:0] command_issue_set_i,
  input  wire logic        pending_packet_set_i,
  input  wire logic        signature_update_req_i,
  input  wire logic        reg_fis_intr_clr_i,
  input  wire logic        global_pending_clr_i,
  input  wire logic        ccc_count_clr_i,
  input  wire logic        atapi_start_i,
  input  wire logic [15:0] current_transfer_count_i,
  input  wire logic [127:0] packet_command_area_i,
  input  wire logic [3:0]  cmd_header_pm_port_i,
  input  wire logic [31:0] bytes_transferred_i,
  input  wire logic        tx_ready_i,
  input  wire logic        tx_ok_i,
  input  wire logic        tx_err_i,
  input  wire logic        rx_fis_valid_i,
  input  wire logic [159:0] rx_fis_i,
  input  wire logic        mem_wr_ready_i,
  output logic             rx_fis_ready_o,
  output logic             tx_valid_o,
  output logic [31:0]      tx_data_o,
  output logic             tx_last_o,
  output logic             mem_wr_valid_o,
  output logic [31:0]      mem_wr_addr_o,
  output logic [31:0]      mem_wr_data_o,
  output logic             prd_wr_valid_o,
  output logic [4:0]       prd_wr_slot_o,
  output logic [31:0]      prd_wr_count_o,
  output logic [7:0]       task_file_status_byte_o,
  output logic [7:0]       task_file_error_byte_o,
  output logic [31:0]      command_issue_bits_o,
  output logic [5:0]       issued_slot_tracker_o,
  output logic [15:0]      pending_packet_transfer_o,
  output logic             pending_signature_update_o,
  output logic [31:0]      device_signature_reg_o,
  output logic [7:0]       coalesced_completion_count_o,
  output logic             reg_fis_intr_status_o,
  output logic             global_port_intr_pending_o,
  output logic             port_intr_o,
  output logic             fatal_o,
  output logic             fatal_taskfile_o,
  output logic             pio_update_o,
  output logic             aggr_o
);
  import rfs_pkg::*;

  typedef struct packed {
    rfs_state_t                 state;
    logic [4:0][31:0]           fis;
    logic [2:0]                 word_idx;
    logic [2:0]                 tx_words;
    logic [31:0]                mem_addr;
    logic [31:0]                mem_data;
    logic                       prd_valid;
    logic [4:0]                 prd_slot;
    logic [31:0]                prd_count;
    logic [7:0]                 tfd_status;
    logic [7:0]                 tfd_error;
    logic [31:0]                ci_bits;
    logic [NUM_PM_PORTS-1:0][5:0] issue_slot;
    logic [NUM_PM_PORTS-1:0]    pkt_pending;
    logic                       sig_pending;
    logic [31:0]                signature;
    logic [7:0]                 ccc_count;
    logic                       dhr_status;
    logic                       global_pending;
    logic                       intr;
    logic                       fatal;
    logic                       fatal_tf;
    logic                       pio_update;
    logic                       aggr;
    logic [1:0][32:0]           buf_mem;
    logic                       buf_wr_ptr;
    logic                       buf_rd_ptr;
    logic [1:0]                 buf_count;
  } rfs_regs_t;

  rfs_regs_t r;
  rfs_regs_t next_r;

  logic        buf_in_valid;
  logic [32:0] buf_in_word;
  logic        buf_in_ready;
  logic        buf_push;
  logic        buf_pop;
  logic [15:0] payload_bytes;
  logic [2:0]  payload_words;
  logic [5:0]  cur_slot;
  logic [4:0]  cur_slot_idx;
  logic [7:0]  fis_status;
  logic        fis_ibit;
  logic        ccc_branch;

  // two-entry buffer toward the link transmitter
  assign buf_in_ready = (r.buf_count != 2'h2);
  assign buf_push     = buf_in_valid && buf_in_ready;
  assign tx_valid_o   = (r.buf_count != 2'h0);
  assign tx_data_o    = r.buf_mem[r.buf_rd_ptr][31:0];
  assign tx_last_o    = r.buf_mem[r.buf_rd_ptr][32];
  assign buf_pop      = tx_valid_o && tx_ready_i;

  always_comb begin
    if (current_transfer_count_i < PACKET_CMD_MAX_BYTES) begin
      payload_bytes = current_transfer_count_i;
    end else begin
      payload_bytes = PACKET_CMD_MAX_BYTES;
    end
  end
  assign payload_words = 3'(payload_bytes[4:2]) + {2'h0, |payload_bytes[1:0]};

  assign cur_slot     = r.issue_slot[current_pm_port_i];
  assign cur_slot_idx = cur_slot[4:0];
  assign fis_status   = r.fis[0][FIS_STATUS_LSB +: 8];
  assign fis_ibit     = r.fis[0][FIS_IBIT];
  assign ccc_branch   = ccc_enable_i && !cur_slot[5] && !active_tag_bits_i[cur_slot_idx];

  // data fis word source: header then packet command dwords
  always_comb begin
    buf_in_valid = 1'b0;
    buf_in_word  = 33'h0_0000_0000;
    if (r.state == RFS_ATAPI_SEND) begin
      buf_in_valid = 1'b1;
      if (r.word_idx == 3'h0) begin
        buf_in_word = {(r.tx_words == 3'h0), 20'h0_0000, cmd_header_pm_port_i,
                       FIS_TYPE_DATA};
      end else begin
        buf_in_word = {(r.word_idx == r.tx_words),
                       packet_command_area_i[32*(r.word_idx-3'h1) +: 32]};
      end
    end
  end

  always_comb begin
    next_r            = r;
    next_r.prd_valid  = 1'b0;
    next_r.fatal      = 1'b0;
    next_r.fatal_tf   = 1'b0;
    next_r.pio_update = 1'b0;
    next_r.aggr       = 1'b0;

    // buffer bookkeeping
    if (buf_push) begin
      next_r.buf_mem[r.buf_wr_ptr] = buf_in_word;
      next_r.buf_wr_ptr = ~r.buf_wr_ptr;
    end
    if (buf_pop) begin
      next_r.buf_rd_ptr = ~r.buf_rd_ptr;
    end
    next_r.buf_count = r.buf_count + {1'b0, buf_push} - {1'b0, buf_pop};

    // software-side clears; hardware sets below win
    if (reg_fis_intr_clr_i) begin
      next_r.dhr_status = 1'b0;
      next_r.intr       = 1'b0;
    end
    if (global_pending_clr_i) begin
      next_r.global_pending = 1'b0;
    end
    if (ccc_count_clr_i) begin
      next_r.ccc_count = CCC_COUNT_RESET;
    end

    case (r.state)
      RFS_IDLE: begin
        if (rx_fis_valid_i && rx_fis_i[7:0] == FIS_TYPE_REG_D2H) begin
          next_r.fis        = rx_fis_i;
          next_r.tfd_error  = rx_fis_i[FIS_ERROR_LSB +: 8];
          next_r.tfd_status = rx_fis_i[FIS_STATUS_LSB +: 8];
          next_r.mem_addr   = received_fis_base_i + REGISTER_FIS_OFFSET
                              + (32'(current_pm_port_i) << PM_PORT_AREA_SHIFT);
          next_r.mem_data   = rx_fis_i[31:0];
          next_r.word_idx   = 3'h0;
          next_r.state      = RFS_REG_ENTRY;
        end else if (atapi_start_i) begin
          next_r.word_idx = 3'h0;
          next_r.tx_words = payload_words;
          next_r.state    = RFS_ATAPI_SEND;
        end
      end
      RFS_ATAPI_SEND: begin
        if (buf_push) begin
          next_r.word_idx = r.word_idx + 3'h1;
          if (r.word_idx == r.tx_words) begin
            next_r.state = RFS_ATAPI_WAIT;
          end
        end
      end
      RFS_ATAPI_WAIT: begin
        if (tx_err_i) begin
          next_r.pkt_pending[current_pm_port_i] = 1'b0;
          next_r.fatal = 1'b1;
          next_r.state = RFS_IDLE;
        end else if (tx_ok_i) begin
          next_r.pkt_pending[current_pm_port_i] = 1'b0;
          next_r.pio_update = 1'b1;
          next_r.state = RFS_IDLE;
        end
      end
      RFS_REG_ENTRY: begin
        if (mem_wr_ready_i) begin
          next_r.word_idx = r.word_idx + 3'h1;
          next_r.mem_addr = r.mem_addr + DWORD_BYTES;
          if (r.word_idx == REG_FIS_DWORDS - 3'h1) begin
            next_r.state = RFS_REG_CHECK;
          end else begin
            next_r.mem_data = r.fis[r.word_idx + 3'h1];
          end
        end
      end
      RFS_REG_CHECK: begin
        if (r.tfd_status[STS_ERR_BIT]) begin
          next_r.fatal_tf = 1'b1;
          next_r.state    = RFS_IDLE;
        end else if (!r.tfd_status[STS_BSY_BIT] && !r.tfd_status[STS_DRQ_BIT]) begin
          next_r.state = RFS_CLEAR_CI;
        end else begin
          next_r.state = RFS_UPDATE_SIG;
        end
      end
      RFS_CLEAR_CI: begin
        if (!cur_slot[5]) begin
          next_r.prd_valid = 1'b1;
          next_r.prd_slot  = cur_slot_idx;
          next_r.prd_count = bytes_transferred_i;
          next_r.ci_bits[cur_slot_idx] = 1'b0;
        end
        next_r.issue_slot[current_pm_port_i] = NO_SLOT;
        if (ccc_branch) begin
          next_r.state = RFS_CCC;
        end else if (fis_ibit) begin
          next_r.state = RFS_SET_INTR;
        end else begin
          next_r.state = RFS_UPDATE_SIG;
        end
      end
      RFS_CCC: begin
        next_r.ccc_count = (ccc_count_clr_i ? CCC_COUNT_RESET : r.ccc_count) + 8'h01;
        next_r.state = fis_ibit ? RFS_SET_INTR : RFS_UPDATE_SIG;
      end
      RFS_SET_INTR: begin
        next_r.dhr_status = 1'b1;
        next_r.state = reg_fis_intr_enable_i ? RFS_SET_IS : RFS_UPDATE_SIG;
      end
      RFS_SET_IS: begin
        next_r.global_pending = 1'b1;
        next_r.state = global_intr_enable_i ? RFS_GEN_INTR : RFS_UPDATE_SIG;
      end
      RFS_GEN_INTR: begin
        next_r.intr  = 1'b1;
        next_r.state = RFS_UPDATE_SIG;
      end
      RFS_UPDATE_SIG: begin
        if (r.sig_pending && !fis_switching_enable_i) begin
          next_r.state = RFS_SET_SIG;
        end else begin
          next_r.state = RFS_AGGR;
        end
      end
      RFS_SET_SIG: begin
        next_r.signature   = {r.fis[1][23:0], r.fis[3][7:0]};
        next_r.sig_pending = 1'b0;
        next_r.state       = RFS_AGGR;
      end
      RFS_AGGR: begin
        next_r.aggr  = 1'b1;
        next_r.state = RFS_IDLE;
      end
      default: begin
        next_r.state = RFS_IDLE;
      end
    endcase

    // requests that arrive during a clear are kept
    next_r.ci_bits = next_r.ci_bits | command_issue_set_i;
    if (pending_packet_set_i) begin
      next_r.pkt_pending[current_pm_port_i] = 1'b1;
    end
    if (slot_issue_i) begin
      next_r.issue_slot[current_pm_port_i] = {1'b0, slot_issue_num_i};
    end
    if (signature_update_req_i) begin
      next_r.sig_pending = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      r            <= '0;
      r.state      <= RFS_IDLE;
      r.tfd_status <= TFD_STATUS_RESET;
      r.tfd_error  <= TFD_ERROR_RESET;
      r.signature  <= SIGNATURE_RESET;
      r.ccc_count  <= CCC_COUNT_RESET;
      r.issue_slot <= {NUM_PM_PORTS{NO_SLOT}};
    end else begin
      r <= next_r;
    end
  end

  assign rx_fis_ready_o               = (r.state == RFS_IDLE);
  assign mem_wr_valid_o               = (r.state == RFS_REG_ENTRY);
  assign mem_wr_addr_o                = r.mem_addr;
  assign mem_wr_data_o                = r.mem_data;
  assign prd_wr_valid_o               = r.prd_valid;
  assign prd_wr_slot_o                = r.prd_slot;
  assign prd_wr_count_o               = r.prd_count;
  assign task_file_status_byte_o      = r.tfd_status;
  assign task_file_error_byte_o       = r.tfd_error;
  assign command_issue_bits_o         = r.ci_bits;
  assign issued_slot_tracker_o        = cur_slot;
  assign pending_packet_transfer_o    = r.pkt_pending;
  assign pending_signature_update_o   = r.sig_pending;
  assign device_signature_reg_o       = r.signature;
  assign coalesced_completion_count_o = r.ccc_count;
  assign reg_fis_intr_status_o        = r.dhr_status;
  assign global_port_intr_pending_o   = r.global_pending;
  assign port_intr_o                  = r.intr;
  assign fatal_o                      = r.fatal;
  assign fatal_taskfile_o             = r.fatal_tf;
  assign pio_update_o                 = r.pio_update;
  assign aggr_o                       = r.aggr;
endmodule
`default_nettype wire
